// [src/mitu_consts.svh]
// Constants of the interrupt and trap unit: addresses, bit positions, reset values, timing.
// Assumes inclusion by bare name from the package; the design modules see its macros through the package.
`ifndef MITU_CONSTS_SVH
`define MITU_CONSTS_SVH

// ----------------------------------------
// Register addresses
// ----------------------------------------
`define MITU_ADDR_STATUS_WORD 8'hEF
`define MITU_ADDR_TMR_SER_CTRL 8'hEE
`define MITU_ADDR_STACK_PTR 8'hFD

// ----------------------------------------
// Status word bits
// ----------------------------------------
`define MITU_PSW_CARRY 0
`define MITU_PSW_HALF_CARRY 1
`define MITU_PSW_GIE 2
`define MITU_PSW_EXT_EN 3
`define MITU_PSW_SHIFT_BUSY 4
`define MITU_PSW_EXT_PND 5
`define MITU_PSW_TMR_EN 6
`define MITU_PSW_TMR_PND 7

// ----------------------------------------
// Control register bits
// ----------------------------------------
`define MITU_CTL_EDGE_SEL 2

// ----------------------------------------
// Reset values and constants
// ----------------------------------------
`define MITU_PSW_RESET 8'h00
`define MITU_CTL_RESET 8'h00
`define MITU_PC_RESET 15'h0000
`define MITU_SP_RESET 8'h00
`define MITU_IRQ_VECTOR 15'h00FF
`define MITU_TRAP_OPCODE 8'h00
`define MITU_UNDEF_PROG_DATA 8'h00
`define MITU_UNDEF_DATA_DATA 8'hFF
`define MITU_SP_STEP 8'h02
`define MITU_SP_BYTE 8'h01
`define MITU_PC_STEP 15'h0001
`define MITU_PC_SKIP 15'h0002
`define MITU_ACK_CYCLES 3'h7
// Counter shows 7 down to 1 over the acknowledge; each action is registered
// one count early so that it shows in its own cycle
`define MITU_ACK_LAST 3'h2
`define MITU_ACK_PUSH_LO 3'h7
`define MITU_ACK_PUSH_HI 3'h6
`define MITU_RET_POP_LO 2'h2
`define MITU_RET_POP_HI 2'h1

`endif

// [src/mitu_pkg.sv]
// Types shared by the interrupt and trap unit files.
// Assumes the constants header sits beside it.
package mitu_pkg;
  `include "mitu_consts.svh"

  // ----------------------------------------
  // Sequencer states
  // ----------------------------------------
  typedef enum logic [1:0] {
    MITU_IDLE,
    MITU_ACK,
    MITU_RET
  } mitu_state_type;

  // ----------------------------------------
  // Return flavour
  // ----------------------------------------
  typedef enum logic [1:0] {
    MITU_RET_PLAIN,
    MITU_RET_SKIP,
    MITU_RET_IRQ
  } mitu_ret_type;
endpackage : mitu_pkg

// [src/mitu_edge_detect.sv]
// Edge detector for the external interrupt pin with selectable polarity.
// Assumes the pin is already synchronous to ref_clk.
`timescale 1ns/1ps
module mitu_edge_detect
  import mitu_pkg::*;
(
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire logic pinIn,
  input wire logic fallingSel,
  output logic edgeSeen
);
  logic prevPin_ff;
  logic nxt_prevPin;
  logic armed_ff;
  logic nxt_armed;

  always_comb begin
    nxt_prevPin = pinIn;
    nxt_armed = 1'b1;
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      prevPin_ff <= 1'b0;
      armed_ff <= 1'b0;
    end else begin
      prevPin_ff <= nxt_prevPin;
      armed_ff <= nxt_armed;
    end
  end

  // Held off one cycle after reset: the pin level at release is unknown,
  // so the reset value of the history bit must not count as an edge
  // 0 rising, 1 falling
  assign edgeSeen = armed_ff
    & (fallingSel ? (prevPin_ff & ~pinIn) : (~prevPin_ff & pinIn));
endmodule : mitu_edge_detect

// [src/mcu_interrupt_and_trap_unit.sv]
// Interrupt and trap unit: status/control bits, acknowledge and return sequencing,
// stack push/pop through a data memory port, undefined memory fill values.
// Assumes a core sequencer that pulses instrBoundary and the return strobes and presents fetchOpcode for the trap check,
// and one instruction cycle per ref_clk enable of 1 (inputs synchronous).
`timescale 1ns/1ps
module mcu_interrupt_and_trap_unit
  import mitu_pkg::*;
(
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire logic ext_irq_pin,
  input wire logic tmrUnderflow,
  input wire logic tmrCapture,
  input wire logic instrBoundary,
  input wire logic [7:0] fetchOpcode,
  input wire logic [14:0] nextPc,
  input wire logic plain_return_op,
  input wire logic return_and_skip_op,
  input wire logic return_from_irq_op,
  input wire logic regWrEn,
  input wire logic [7:0] regAddr,
  input wire logic [7:0] regWrData,
  input wire logic progDefined,
  input wire logic [7:0] progRawData,
  input wire logic dataDefined,
  input wire logic [7:0] dataRawData,
  input wire logic [7:0] stackRdData,
  output logic [7:0] processor_status_word,
  output logic [7:0] timer_serial_control,
  output logic global_irq_enable,
  output logic ext_irq_pending,
  output logic tmr_irq_pending,
  output logic seqBusy,
  output logic pcLoad,
  output logic [14:0] pcValue,
  output logic [7:0] stackPtr,
  output logic stackWrEn,
  output logic stackRdEn,
  output logic [7:0] stackAddr,
  output logic [7:0] stackWrData,
  output logic [7:0] progRdData,
  output logic [7:0] dataRdData
);
  // ----------------------------------------
  // State
  // ----------------------------------------
  mitu_state_type state_ff, nxt_state;
  mitu_ret_type retKind_ff, nxt_retKind;
  logic [7:0] psw_ff, nxt_psw;
  logic [7:0] ctl_ff, nxt_ctl;
  logic [2:0] ackCnt_ff, nxt_ackCnt;
  logic [1:0] retCnt_ff, nxt_retCnt;
  logic [14:0] savedPc_ff, nxt_savedPc;
  logic [14:0] pcValue_ff, nxt_pcValue;
  logic pcLoad_ff, nxt_pcLoad;
  logic [7:0] sp_ff, nxt_sp;
  logic stackWr_ff, nxt_stackWr;
  logic stackRd_ff, nxt_stackRd;
  logic [7:0] stackAddr_ff, nxt_stackAddr;
  logic [7:0] stackWrData_ff, nxt_stackWrData;
  logic [7:0] progRd_ff, nxt_progRd;
  logic [7:0] dataRd_ff, nxt_dataRd;
  logic [7:0] popLo_ff, nxt_popLo;
  logic busy_ff, nxt_busy;
  logic extEdge;
  logic irqTake;
  logic trapTake;

  // Stack register lives at the mapped SP location in the core's view
  function automatic logic addrHit(input logic [7:0] a, input logic [7:0] target);
    addrHit = (a == target);
  endfunction : addrHit

  mitu_edge_detect u_edge (
    .ref_clk(ref_clk),
    .rst_n(rst_n),
    .pinIn(ext_irq_pin),
    .fallingSel(ctl_ff[`MITU_CTL_EDGE_SEL]),
    .edgeSeen(extEdge)
  );

  // ----------------------------------------
  // Decision
  // ----------------------------------------
  // Trap is tested first: it cannot be masked and the opcode is already in flight
  assign trapTake = instrBoundary && (state_ff == MITU_IDLE)
    && (fetchOpcode == `MITU_TRAP_OPCODE);
  assign irqTake = instrBoundary && (state_ff == MITU_IDLE) && !trapTake
    && psw_ff[`MITU_PSW_GIE]
    && ((psw_ff[`MITU_PSW_EXT_EN] && psw_ff[`MITU_PSW_EXT_PND])
    || (psw_ff[`MITU_PSW_TMR_EN] && psw_ff[`MITU_PSW_TMR_PND]));

  // ----------------------------------------
  // Next-state logic
  // ----------------------------------------
  always_comb begin
    nxt_state = state_ff;
    nxt_retKind = retKind_ff;
    nxt_psw = psw_ff;
    nxt_ctl = ctl_ff;
    nxt_ackCnt = ackCnt_ff;
    nxt_retCnt = retCnt_ff;
    nxt_savedPc = savedPc_ff;
    nxt_pcValue = pcValue_ff;
    nxt_pcLoad = 1'b0;
    nxt_sp = sp_ff;
    nxt_stackWr = 1'b0;
    nxt_stackRd = 1'b0;
    nxt_stackAddr = stackAddr_ff;
    nxt_stackWrData = stackWrData_ff;
    nxt_popLo = popLo_ff;
    // Software writes first so that hardware sets below win over a clear
    if (regWrEn && addrHit(regAddr, `MITU_ADDR_STATUS_WORD)) begin
      nxt_psw = regWrData;
    end
    if (regWrEn && addrHit(regAddr, `MITU_ADDR_TMR_SER_CTRL)) begin
      nxt_ctl = regWrData;
    end
    if (extEdge) begin
      nxt_psw[`MITU_PSW_EXT_PND] = 1'b1;
    end
    if (tmrUnderflow || tmrCapture) begin
      nxt_psw[`MITU_PSW_TMR_PND] = 1'b1;
    end
    case (state_ff)
      MITU_IDLE: begin
        if (trapTake || irqTake) begin
          nxt_state = MITU_ACK;
          nxt_ackCnt = `MITU_ACK_CYCLES;
          // Trap saves its own address so return-and-skip lands past it
          nxt_savedPc = trapTake ? pcValue_ff : nextPc;
          if (irqTake) begin
            nxt_psw[`MITU_PSW_GIE] = 1'b0;
          end
        end else if (instrBoundary && (plain_return_op || return_and_skip_op
            || return_from_irq_op)) begin
          nxt_state = MITU_RET;
          nxt_retCnt = `MITU_RET_POP_LO;
          nxt_retKind = return_from_irq_op ? MITU_RET_IRQ
            : (return_and_skip_op ? MITU_RET_SKIP : MITU_RET_PLAIN);
          nxt_stackRd = 1'b1;
          // Low byte sits above the high byte, so it is popped first
          nxt_stackAddr = sp_ff + `MITU_SP_STEP;
        end else if (instrBoundary) begin
          nxt_pcValue = nextPc;
        end
      end
      MITU_ACK: begin
        nxt_ackCnt = ackCnt_ff - 3'h1;
        if (ackCnt_ff == `MITU_ACK_PUSH_LO) begin
          nxt_stackWr = 1'b1;
          nxt_stackAddr = sp_ff;
          nxt_stackWrData = savedPc_ff[7:0];
        end
        if (ackCnt_ff == `MITU_ACK_PUSH_HI) begin
          nxt_stackWr = 1'b1;
          nxt_stackAddr = sp_ff - `MITU_SP_BYTE;
          nxt_stackWrData = {1'b0, savedPc_ff[14:8]};
          nxt_sp = sp_ff - `MITU_SP_STEP;
        end
        // Vector load and idle share one edge: the core may issue after pcLoad
        if (ackCnt_ff == `MITU_ACK_LAST) begin
          nxt_pcValue = `MITU_IRQ_VECTOR;
          nxt_pcLoad = 1'b1;
          nxt_state = MITU_IDLE;
        end
      end
      MITU_RET: begin
        nxt_retCnt = retCnt_ff - 2'h1;
        if (retCnt_ff == `MITU_RET_POP_LO) begin
          nxt_stackRd = 1'b1;
          nxt_stackAddr = sp_ff + `MITU_SP_BYTE;
        end
        if (retCnt_ff == `MITU_RET_POP_LO - 2'h1) begin
          nxt_popLo = stackRdData;
        end
        if (retCnt_ff == `MITU_RET_POP_HI - 2'h1) begin
          // Unbalanced pop from the top reads ones, giving the all-ones address
          nxt_pcValue = {stackRdData[6:0], popLo_ff};
          if (retKind_ff == MITU_RET_SKIP) begin
            nxt_pcValue = {stackRdData[6:0], popLo_ff} + `MITU_PC_SKIP;
          end
          nxt_pcLoad = 1'b1;
          nxt_sp = sp_ff + `MITU_SP_STEP;
          if (retKind_ff == MITU_RET_IRQ) begin
            nxt_psw[`MITU_PSW_GIE] = 1'b1;
          end
          nxt_state = MITU_IDLE;
        end
      end
      default: begin
        nxt_state = MITU_IDLE;
      end
    endcase
    // Software write to the stack pointer wins over the sequencer's update
    if (regWrEn && addrHit(regAddr, `MITU_ADDR_STACK_PTR)) begin
      nxt_sp = regWrData;
    end
    // Registered so that the busy output comes straight from a flip-flop
    nxt_busy = (nxt_state != MITU_IDLE);
  end

  // ----------------------------------------
  // Memory read fill values
  // ----------------------------------------
  always_comb begin
    nxt_progRd = progDefined ? progRawData : `MITU_UNDEF_PROG_DATA;
    nxt_dataRd = dataDefined ? dataRawData : `MITU_UNDEF_DATA_DATA;
  end

  // ----------------------------------------
  // Registers
  // ----------------------------------------
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      state_ff <= MITU_IDLE;
      retKind_ff <= MITU_RET_PLAIN;
      psw_ff <= `MITU_PSW_RESET;
      ctl_ff <= `MITU_CTL_RESET;
      ackCnt_ff <= 3'h0;
      retCnt_ff <= 2'h0;
      savedPc_ff <= `MITU_PC_RESET;
      pcValue_ff <= `MITU_PC_RESET;
      pcLoad_ff <= 1'b0;
      sp_ff <= `MITU_SP_RESET;
      stackWr_ff <= 1'b0;
      stackRd_ff <= 1'b0;
      stackAddr_ff <= `MITU_SP_RESET;
      stackWrData_ff <= 8'h00;
      progRd_ff <= `MITU_UNDEF_PROG_DATA;
      dataRd_ff <= `MITU_UNDEF_DATA_DATA;
      popLo_ff <= 8'h00;
      busy_ff <= 1'b0;
    end else begin
      state_ff <= nxt_state;
      retKind_ff <= nxt_retKind;
      psw_ff <= nxt_psw;
      ctl_ff <= nxt_ctl;
      ackCnt_ff <= nxt_ackCnt;
      retCnt_ff <= nxt_retCnt;
      savedPc_ff <= nxt_savedPc;
      pcValue_ff <= nxt_pcValue;
      pcLoad_ff <= nxt_pcLoad;
      sp_ff <= nxt_sp;
      stackWr_ff <= nxt_stackWr;
      stackRd_ff <= nxt_stackRd;
      stackAddr_ff <= nxt_stackAddr;
      stackWrData_ff <= nxt_stackWrData;
      progRd_ff <= nxt_progRd;
      dataRd_ff <= nxt_dataRd;
      popLo_ff <= nxt_popLo;
      busy_ff <= nxt_busy;
    end
  end

  // ----------------------------------------
  // Outputs
  // ----------------------------------------
  // Plain register copies, no decoding on the way out
  assign processor_status_word = psw_ff;
  assign timer_serial_control = ctl_ff;
  assign global_irq_enable = psw_ff[`MITU_PSW_GIE];
  assign ext_irq_pending = psw_ff[`MITU_PSW_EXT_PND];
  assign tmr_irq_pending = psw_ff[`MITU_PSW_TMR_PND];
  assign seqBusy = busy_ff;
  assign pcLoad = pcLoad_ff;
  assign pcValue = pcValue_ff;
  assign stackPtr = sp_ff;
  assign stackWrEn = stackWr_ff;
  assign stackRdEn = stackRd_ff;
  assign stackAddr = stackAddr_ff;
  assign stackWrData = stackWrData_ff;
  assign progRdData = progRd_ff;
  assign dataRdData = dataRd_ff;
endmodule : mcu_interrupt_and_trap_unit

// [tb/mitu_checker_sva.sv]
// Port-level assertions for the interrupt and trap unit.
// Assumes one clock, ref_clk, and asynchronous active-low rst_n.
`timescale 1ns/1ps
module mitu_checker_sva
  import mitu_pkg::*;
(
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire logic ext_irq_pin,
  input wire logic instrBoundary,
  input wire logic [7:0] fetchOpcode,
  input wire logic plain_return_op,
  input wire logic return_and_skip_op,
  input wire logic return_from_irq_op,
  input wire logic regWrEn,
  input wire logic [7:0] processor_status_word,
  input wire logic [7:0] timer_serial_control,
  input wire logic global_irq_enable,
  input wire logic ext_irq_pending,
  input wire logic tmr_irq_pending,
  input wire logic seqBusy,
  input wire logic pcLoad,
  input wire logic [14:0] pcValue,
  input wire logic [7:0] stackPtr,
  input wire logic stackWrEn,
  input wire logic stackRdEn,
  input wire logic [7:0] stackAddr
);
  default clocking @(posedge ref_clk);
  endclocking
  default disable iff (!rst_n);
  logic req;
  logic irqOk;
  // Register writes are left out: a write may change the enables in the same cycle
  assign req = instrBoundary & !seqBusy & !regWrEn;
  assign irqOk = global_irq_enable & ((processor_status_word[3] & ext_irq_pending) |
    (processor_status_word[6] & tmr_irq_pending));
  sequence s_irqTake;
    req && !plain_return_op && !return_and_skip_op && !return_from_irq_op &&
      fetchOpcode != 8'h00 && irqOk;
  endsequence
  sequence s_trapTake;
    req && !plain_return_op && !return_and_skip_op && !return_from_irq_op &&
      fetchOpcode == 8'h00;
  endsequence
  sequence s_retTake;
    req && (plain_return_op || return_and_skip_op || return_from_irq_op);
  endsequence
  property p_ackSeq;
    s_irqTake or s_trapTake |=> (seqBusy && !pcLoad)[*6] ##1 (pcLoad && pcValue == 15'h00FF);
  endproperty
  a_ackSeq: assert property (p_ackSeq) else $error("acknowledge timing or vector wrong");
  property p_ackGie;
    s_irqTake |-> ##[1:2] !global_irq_enable;
  endproperty
  a_ackGie: assert property (p_ackGie) else $error("global enable kept after ack");
  property p_trapGie;
    s_trapTake |=> $stable(global_irq_enable)[*3];
  endproperty
  a_trapGie: assert property (p_trapGie) else $error("trap changed global enable");
  property p_gate;
    req && !plain_return_op && !return_and_skip_op && !return_from_irq_op &&
      fetchOpcode != 8'h00 && !irqOk |=> !seqBusy;
  endproperty
  a_gate: assert property (p_gate) else $error("masked interrupt taken");
  property p_push;
    s_irqTake or s_trapTake |-> ##2 (stackWrEn && stackAddr == $past(stackPtr, 2))
      ##3 (stackPtr == $past(stackPtr, 5) - 8'h02);
  endproperty
  a_push: assert property (p_push) else $error("stack push wrong");
  property p_ret;
    s_retTake |=> (stackRdEn && stackAddr == $past(stackPtr) + 8'h02)
      ##1 (stackRdEn && stackAddr == $past(stackPtr, 2) + 8'h01)
      ##2 (pcLoad && stackPtr == $past(stackPtr, 4) + 8'h02);
  endproperty
  a_ret: assert property (p_ret) else $error("stack pop wrong");
  property p_retiGie;
    s_retTake ##0 return_from_irq_op |-> ##4 global_irq_enable;
  endproperty
  a_retiGie: assert property (p_retiGie) else $error("return from irq left enable off");
  property p_edge;
    ($rose(ext_irq_pin) && !timer_serial_control[2]) ||
      ($fell(ext_irq_pin) && timer_serial_control[2]) |-> ##[1:3] ext_irq_pending;
  endproperty
  a_edge: assert property (p_edge) else $error("pin edge not flagged");
endmodule : mitu_checker_sva

bind mcu_interrupt_and_trap_unit mitu_checker_sva u_sva (.*);

// [tb/mitu_stack_model.sv]
// Data memory behind the stack port of the unit.
// Assumes reads answer one cycle after the strobe.
`timescale 1ns/1ps
module mitu_stack_model (
  input wire logic ref_clk,
  input wire logic stackWrEn,
  input wire logic stackRdEn,
  input wire logic [7:0] stackAddr,
  input wire logic [7:0] stackWrData,
  output logic [7:0] stackRdData
);
  logic [7:0] mem_ff [256];
  initial begin
    foreach (mem_ff[i]) mem_ff[i] = 8'hFF;
    stackRdData = 8'h00;
  end
  // Idle cycles show the inverse, so a stale byte does not pass for data on the cycle after a read
  always @(posedge ref_clk) begin
    if (stackWrEn) mem_ff[stackAddr] <= stackWrData;
    stackRdData <= stackRdEn ? mem_ff[stackAddr] : ~stackRdData;
  end
endmodule : mitu_stack_model

// [tb/mcu_interrupt_and_trap_unit_test.sv]
// Bench playing the core sequencer against the interrupt and trap unit.
// Assumes the stack model on the stack port and the bound checker.
`timescale 1ns/1ps
module mcu_interrupt_and_trap_unit_test import mitu_pkg::*;;
  logic ref_clk = 1'b0, rst_n = 1'b0, ext_irq_pin = 1'b0, tmrUnderflow = 1'b0;
  logic tmrCapture = 1'b0, instrBoundary = 1'b0, regWrEn = 1'b0;
  logic plain_return_op = 1'b0, return_and_skip_op = 1'b0, return_from_irq_op = 1'b0;
  logic progDefined = 1'b1, dataDefined = 1'b1;
  logic [7:0] fetchOpcode = 8'h01, regAddr = 8'h00, regWrData = 8'h00;
  logic [7:0] progRawData = 8'h5A, dataRawData = 8'h3C;
  logic [14:0] nextPc = 15'h0000;
  logic [7:0] stackRdData, processor_status_word, timer_serial_control, stackPtr;
  logic [7:0] stackAddr, stackWrData, progRdData, dataRdData;
  logic global_irq_enable, ext_irq_pending, tmr_irq_pending, seqBusy, pcLoad;
  logic stackWrEn, stackRdEn;
  logic [14:0] pcValue;
  int mismatches = 0, samples_checked = 0;
  logic [15:0] cyc = 16'h0000;
  mcu_interrupt_and_trap_unit u_dut (.*);
  mitu_stack_model u_mem (.*);
  initial forever #20 ref_clk = ~ref_clk;
  task automatic tick(input int n = 1);
    repeat (n) @(posedge ref_clk);
    #1;
  endtask : tick
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    samples_checked++;
    if (got !== exp) begin
      mismatches++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task automatic regWr(input logic [7:0] a, input logic [7:0] d);
    regAddr = a;
    regWrData = d;
    regWrEn = 1'b1;
    tick();
    regWrEn = 1'b0;
    tick();
  endtask : regWr
  // Counts cycles up to pcLoad; 20 means nothing was taken
  task automatic issue(input logic [7:0] op, input logic [2:0] ret);
    instrBoundary = 1'b1;
    fetchOpcode = op;
    {return_from_irq_op, return_and_skip_op, plain_return_op} = ret;
    tick();
    instrBoundary = 1'b0;
    {return_from_irq_op, return_and_skip_op, plain_return_op} = 3'b000;
    cyc = 1;
    while (pcLoad !== 1'b1 && cyc < 20) begin
      tick();
      cyc++;
    end
    tick();
  endtask : issue
  task automatic pinTo(input logic v, input logic exp);
    ext_irq_pin = v;
    tick(4);
    chk(ext_irq_pending, exp);
  endtask : pinTo
  task automatic print_verdict();
    $display("comparisons %0d, mismatches %0d", samples_checked, mismatches);
    if (mismatches == 0 && samples_checked > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask : print_verdict
  initial begin
    #100000;
    mismatches++;
    print_verdict();
  end
  initial begin
    tick(8);
    rst_n = 1'b1;
    chk(processor_status_word, 8'h00);
    chk(dataRdData, 8'hFF);
    regWr(8'hFD, 8'h6F);
    pinTo(1'b1, 1'b1);
    regWr(8'hEF, 8'h00);
    pinTo(1'b0, 1'b0);
    regWr(8'hEE, 8'h04);
    chk(timer_serial_control, 8'h04);
    pinTo(1'b1, 1'b0);
    pinTo(1'b0, 1'b1);
    $display("test edge done");
    regWr(8'hEF, 8'h2C);
    chk(processor_status_word, 8'h2C);
    nextPc = 15'h1234;
    issue(8'h12, 3'b000);
    chk(cyc, 7);
    chk(pcValue, 15'h00FF);
    chk({global_irq_enable, ext_irq_pending}, 2'b01);
    chk(stackPtr, 8'h6D);
    chk({u_mem.mem_ff[8'h6E], u_mem.mem_ff[8'h6F]}, 16'h1234);
    issue(8'h12, 3'b000);
    chk(cyc, 20);
    regWr(8'hEF, 8'h2C);
    nextPc = 15'h0456;
    issue(8'h12, 3'b000);
    chk(cyc, 7);
    issue(8'h01, 3'b001);
    chk(cyc, 4);
    chk(pcValue, 15'h0456);
    chk({global_irq_enable, stackPtr}, 9'h06D);
    regWr(8'hEF, 8'h08);
    issue(8'h01, 3'b100);
    chk(pcValue, 15'h1234);
    chk({global_irq_enable, stackPtr}, 9'h16F);
    $display("test external done");
    for (int i = 1; i < 3; i++) begin
      {tmrUnderflow, tmrCapture} = 2'(i);
      tick();
      {tmrUnderflow, tmrCapture} = 2'b00;
      tick();
      chk(tmr_irq_pending, 1'b1);
      issue(8'h12, 3'b000);
      chk(cyc, 20);
      regWr(8'hEF, 8'h04);
      chk(tmr_irq_pending, 1'b0);
    end
    regWr(8'hEF, 8'h44);
    tmrUnderflow = 1'b1;
    tick();
    tmrUnderflow = 1'b0;
    nextPc = 15'h0777;
    issue(8'h12, 3'b000);
    chk(cyc, 7);
    issue(8'h01, 3'b010);
    chk(pcValue, 15'h0779);
    chk(global_irq_enable, 1'b0);
    $display("test timer done");
    regWr(8'hEF, 8'h04);
    issue(8'h00, 3'b000);
    chk(cyc, 7);
    chk({global_irq_enable, stackPtr}, 9'h16D);
    issue(8'h01, 3'b010);
    chk(stackPtr, 8'h6F);
    chk(pcValue, 15'h077B);
    $display("test trap done");
    issue(8'h01, 3'b001);
    chk(pcValue, 15'h7FFF);
    chk(stackPtr, 8'h71);
    progDefined = 1'b0;
    dataDefined = 1'b0;
    tick();
    chk({progRdData, dataRdData}, 16'h00FF);
    progDefined = 1'b1;
    dataDefined = 1'b1;
    tick();
    chk({progRdData, dataRdData}, 16'h5A3C);
    $display("test undefined done");
    print_verdict();
  end
endmodule : mcu_interrupt_and_trap_unit_test
